// ---- logic/kpi_keypad_irq.sv ----
`timescale 1ns/1ps
//==============================================================================
// keypad pin interrupt controller with APB register access
module kpi_keypad_irq #(
  parameter int N = kpi_pkg::NPINS
) (
  input  wire logic                        pclk,               // bus clock
  input  wire logic                        presetn,            // async reset, low
  input  wire logic                        clk_en,             // freezes state when low
  input  wire logic                        psel,               // apb select
  input  wire logic                        penable,            // apb enable
  input  wire logic                        pwrite,             // apb direction
  input  wire logic [kpi_pkg::ADDR_W-1:0]  paddr,              // apb address
  input  wire logic [kpi_pkg::DATA_W-1:0]  pwdata,             // apb write data
  output logic      [kpi_pkg::DATA_W-1:0]  prdata,             // apb read data
  output logic                             pready,             // apb ready
  output logic                             pslverr,            // apb error
  input  wire logic [N-1:0]                keypad_inputs,      // asynchronous pins
  input  wire logic                        vector_fetch_ack,   // cpu vector fetch
  input  wire logic                        break_state,        // debug break active
  input  wire logic                        break_clear_enable, // clears allowed in break
  output logic                             irq_req,            // interrupt to cpu
  output logic                             wake_req,           // wake from wait/stop
  output logic      [N-1:0]                pull_up_en,         // pin pullup on
  output logic      [N-1:0]                pull_down_en,       // pin pulldown on
  output logic      [N-1:0]                pin_force_input     // override direction
);

  //============================================================================
  // state
  typedef struct packed {
    logic                       mode;
    logic                       mask;
    logic [N-1:0]               en;
    logic [N-1:0]               pol;
    logic                       latch;
    logic                       prev_any;
    logic                       irq;
    logic                       wake;
    logic [N-1:0]               pull_up;
    logic [N-1:0]               pull_dn;
    logic [N-1:0]               force_in;
    logic                       ready;
    logic [kpi_pkg::DATA_W-1:0] rdata;
    logic                       slverr;
  } kpi_state_s;

  kpi_state_s st_ff;
  kpi_state_s nxt_st;

  //============================================================================
  // helpers
  function automatic logic hit(input logic [kpi_pkg::ADDR_W-1:0] a,
                               input logic [11:0]                off);
    hit = (a == off);
  endfunction

  function automatic logic [kpi_pkg::DATA_W-1:0] widen(input logic [N-1:0] v);
    widen = '0;
    widen[N-1:0] = v; // reserved upper bits stay zero
  endfunction

  function automatic logic [kpi_pkg::DATA_W-1:0] status_word(input logic pend,
                                                              input logic msk,
                                                              input logic md);
    status_word = '0;
    status_word[kpi_pkg::BIT_PEND] = pend;
    status_word[kpi_pkg::BIT_MASK] = msk;
    status_word[kpi_pkg::BIT_MODE] = md;
  endfunction

  //============================================================================
  // pin synchroniser
  kpi_sync_if #(.N(N)) sync_bus ();

  assign sync_bus.raw = keypad_inputs;
  assign sync_bus.ce  = clk_en;

  kpi_pin_sync #(.N(N)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .sb      (sync_bus)
  );

  //============================================================================
  // detection and bus decode
  logic [N-1:0] pin_asserted;
  logic         any_asserted;
  logic         set_req;
  logic         setup_ph;
  logic         wr_acc;
  logic         wr_status;
  logic         clear_ok;
  logic         ack;
  logic         pend;

  always_comb
  begin
    pin_asserted = st_ff.en & ~(sync_bus.stable ^ st_ff.pol);   // R1 R2
    any_asserted = |pin_asserted;
    // one edge on the combined level: a held input hides new edges
    set_req      = any_asserted & ~st_ff.prev_any;             // R4 R5 R9
    // level mode: request also stands while any input held, so ack and
    // release may come in either order
    pend         = st_ff.latch | (st_ff.mode & st_ff.prev_any); // R6 R7
    setup_ph     = psel & ~penable;
    wr_acc       = psel & penable & st_ff.ready & pwrite;
    wr_status    = wr_acc & hit(paddr, kpi_pkg::OFF_STATUS);
    clear_ok     = ~break_state | break_clear_enable;          // R18
    ack          = vector_fetch_ack                            // R8
                 | (wr_status & pwdata[kpi_pkg::BIT_ACK] & clear_ok);
  end

  //============================================================================
  // next state
  always_comb
  begin
    nxt_st = st_ff;
    if (clk_en)
    begin
      if (wr_status)
      begin
        nxt_st.mask = pwdata[kpi_pkg::BIT_MASK];               // R13
        nxt_st.mode = pwdata[kpi_pkg::BIT_MODE];
      end
      if (wr_acc && hit(paddr, kpi_pkg::OFF_ENABLE))
        nxt_st.en = pwdata[N-1:0];                             // R1 R20
      if (wr_acc && hit(paddr, kpi_pkg::OFF_POLARITY))
        nxt_st.pol = pwdata[N-1:0];                            // R2
      // set wins over acknowledge in the same cycle; level mode hold comes from the mode term
      nxt_st.latch    = set_req | (st_ff.latch & ~ack);        // R7 R11
      nxt_st.prev_any = any_asserted;                          // R21
      nxt_st.irq      = (nxt_st.latch | (nxt_st.mode & any_asserted))
                      & ~nxt_st.mask;                          // R13
      nxt_st.wake     = (nxt_st.latch | (nxt_st.mode & any_asserted))
                      & ~nxt_st.mask;                          // R17
      nxt_st.pull_up  = nxt_st.en & ~nxt_st.pol;               // R3
      nxt_st.pull_dn  = nxt_st.en & nxt_st.pol;                // R3
      nxt_st.force_in = nxt_st.en;                             // R14
      // no wait state: data captured at setup, ready in first access cycle
      nxt_st.ready  = setup_ph;
      nxt_st.slverr = 1'b0;
      if (setup_ph)
      begin
        nxt_st.rdata = '0;
        if (hit(paddr, kpi_pkg::OFF_STATUS))
          nxt_st.rdata = status_word(pend, st_ff.mask,         // R12 R19
                                     st_ff.mode);
        else if (hit(paddr, kpi_pkg::OFF_ENABLE))
          nxt_st.rdata = widen(st_ff.en);                      // R20
        else if (hit(paddr, kpi_pkg::OFF_POLARITY))
          nxt_st.rdata = widen(st_ff.pol);
        else
          nxt_st.slverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff      <= '0;                                        // R10
      st_ff.mode <= kpi_pkg::RST_MODE;                         // R10
      st_ff.mask <= kpi_pkg::RST_MASK;
    end
    else
      st_ff <= nxt_st;
  end

  assign prdata          = st_ff.rdata;
  assign pready          = st_ff.ready;
  assign pslverr         = st_ff.slverr;
  assign irq_req         = st_ff.irq;
  assign wake_req        = st_ff.wake;
  assign pull_up_en      = st_ff.pull_up;
  assign pull_down_en    = st_ff.pull_dn;
  assign pin_force_input = st_ff.force_in;

  //============================================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_latch_sets: assert property ( // R4
    clk_en && any_asserted && !st_ff.prev_any |=> st_ff.latch && pending_bit())
    else $error("latch did not set on new assertion");

  function automatic logic pending_bit();
    pending_bit = st_ff.latch;
  endfunction

  a_edge_hidden: assert property ( // R5
    clk_en && !st_ff.mode && st_ff.prev_any && any_asserted && !st_ff.latch
    |=> !st_ff.latch)
    else $error("edge latched while another input held");

  a_level_holds: assert property ( // R6
    clk_en && st_ff.mode && any_asserted && !wr_status |=> pend)
    else $error("level request dropped while asserted");

  a_level_release: assert property ( // R7
    clk_en && st_ff.mode && ack && !any_asserted |=> !pend)
    else $error("level request not cleared after ack and release");

  a_edge_ack: assert property ( // R11
    clk_en && !st_ff.mode && ack && !set_req |=> !st_ff.latch)
    else $error("edge mode ack did not clear latch");

  a_mask_gate: assert property ( // R13
    st_ff.irq == (pend && !st_ff.mask))
    else $error("interrupt output disagrees with latch and mask");

  a_pend_read: assert property ( // R12
    clk_en && setup_ph && !pwrite && hit(paddr, kpi_pkg::OFF_STATUS)
    |=> prdata[kpi_pkg::BIT_PEND] == $past(pend) && pready)
    else $error("pending flag read wrong");

  a_ack_zero: assert property ( // R19
    pready && !pslverr |-> !prdata[kpi_pkg::BIT_ACK] || !$past(hit(paddr, kpi_pkg::OFF_STATUS)))
    else $error("acknowledge bit read as one");

  a_break_hold: assert property ( // R18
    clk_en && break_state && !break_clear_enable && !vector_fetch_ack && st_ff.latch
    |=> st_ff.latch)
    else $error("status cleared during protected break");

  a_pull_sense: assert property ( // R3
    ((pull_up_en & pull_down_en) == '0) && (pin_force_input == st_ff.en)
    && (pull_up_en == (st_ff.en & ~st_ff.pol)))
    else $error("pull devices do not follow polarity");

  a_reserved_zero: assert property ( // R20
    clk_en && setup_ph && hit(paddr, kpi_pkg::OFF_ENABLE)
    |=> prdata[kpi_pkg::DATA_W-1:N] == '0)
    else $error("reserved enable bits read non-zero");

  c_edge_irq: cover property (!st_ff.latch ##1 st_ff.latch ##1 irq_req);
  c_level_ack: cover property (st_ff.mode && st_ff.latch && ack ##1 st_ff.latch);
  c_break_block: cover property (break_state && !break_clear_enable && wr_status);
  c_unmapped: cover property (pready && pslverr);

endmodule // kpi_keypad_irq

// ---- logic/kpi_pin_sync.sv ----
`timescale 1ns/1ps
//==============================================================================
// three-stage pin synchroniser; a change is taken once stages two and three agree
module kpi_pin_sync #(
  parameter int N = 6
) (
  input  wire logic pclk,    // bus clock
  input  wire logic presetn, // async reset, active low
  kpi_sync_if.sync  sb       // raw pins in, settled levels out
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] stable;
  } kpi_sync_s;

  kpi_sync_s st_ff;
  kpi_sync_s nxt_st;
  logic [N-1:0] agree;

  always_comb
  begin
    nxt_st = st_ff;
    agree  = ~(st_ff.s2 ^ st_ff.s3);
    if (sb.ce)
    begin
      nxt_st.s1     = sb.raw;                                       // R21
      nxt_st.s2     = st_ff.s1;
      nxt_st.s3     = st_ff.s2;
      nxt_st.stable = (st_ff.s3 & agree) | (st_ff.stable & ~agree); // R21
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign sb.stable = st_ff.stable;

endmodule // kpi_pin_sync

// ---- logic/kpi_pkg.sv ----
//==============================================================================
// Summary of operation
// R1 - each keypad input has its own enable bit, armed independently
// R2 - polarity bit 1 selects rising/high, 0 selects falling/low
// R3 - enabled input turns on pullup for falling/low, pulldown for rising/high
// R4 - latch sets when at least one enabled input becomes asserted
// R5 - edge-only: edge ignored while another enabled input already asserted
// R6 - edge-and-level: request stays while any enabled input asserted
// R7 - level mode clears only after acknowledge and all inputs deasserted
// R8 - acknowledge comes from vector fetch or software writing 1
// R9 - acknowledge does not block later edges; new edge latches again
// R10 - reset clears pending request and sensitivity bit even if input asserted
// R11 - edge-only mode: acknowledge clears latch at once
// R12 - pending flag reads 1 while request pending, regardless of mask
// R13 - mask 1 blocks interrupt request output, mask 0 allows it
// R14 - enable bit forces the pin to act as input
// R15 - software masks, sets polarity, enables, acknowledges, then unmasks
// R16 - level input acknowledged after load delay; edge input at once
// R17 - keeps detecting in wait and stop; unmasked request wakes MCU
// R18 - in break, software clears ignored unless break clear enable is 1
// R19 - acknowledge bit is write-only and always reads 0
// R20 - reserved enable bits read 0; software writes 0
// R21 - pins synchronised to bus clock, edges from consecutive samples
package kpi_pkg;

  //============================================================================
  // sizes
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NPINS  = 6;

  //============================================================================
  // register map (byte addresses)
  localparam logic [11:0] OFF_STATUS   = 12'h000;
  localparam logic [11:0] OFF_ENABLE   = 12'h004;
  localparam logic [11:0] OFF_POLARITY = 12'h008;

  //============================================================================
  // status/control field positions
  localparam int BIT_MODE = 0;
  localparam int BIT_MASK = 1;
  localparam int BIT_ACK  = 2;
  localparam int BIT_PEND = 3;

  //============================================================================
  // reset values
  localparam logic RST_MODE = 1'b0;
  localparam logic RST_MASK = 1'b0;

endpackage

// ---- logic/kpi_sync_if.sv ----
`timescale 1ns/1ps
//==============================================================================
// carrier between the pin synchroniser and the controller
interface kpi_sync_if #(
  parameter int N = 6
);
  logic [N-1:0] raw;
  logic         ce;
  logic [N-1:0] stable;

  modport sync (input raw, input ce, output stable);
  modport user (output raw, output ce, input stable);
endinterface

// ---- verif/kpi_key_model.sv ----
`timescale 1ns/1ps
//=====
// keys: driven while pressed, else pulled; unpulled pins wander
module kpi_key_model #(
  parameter int N = 6
) (
  input  wire logic         pclk,    // bus clock
  input  wire logic [N-1:0] drv_en,  // key pressed
  input  wire logic [N-1:0] drv_val, // level while pressed
  input  wire logic [N-1:0] pu_en,   // pullup on
  input  wire logic [N-1:0] pd_en,   // pulldown on
  output logic      [N-1:0] keys     // pin levels
);
  logic [N-1:0] wander_ff = '0;
  always_ff @(posedge pclk)
  begin
    wander_ff <= ~wander_ff;
  end
  // floating pin never holds a steady value
  always_comb
  begin
    keys = (drv_en & drv_val) | (~drv_en & (pu_en | (~pd_en & wander_ff)));
  end
endmodule // kpi_key_model

// ---- verif/test_keypad_pin_interrupt.sv ----
`timescale 1ns/1ps
//=====
module test_keypad_pin_interrupt;
  localparam logic [31:0] MD = 32'h1 << kpi_pkg::BIT_MODE;
  localparam logic [31:0] MK = 32'h1 << kpi_pkg::BIT_MASK;
  localparam logic [31:0] AK = 32'h1 << kpi_pkg::BIT_ACK;
  localparam logic [31:0] PN = 32'h1 << kpi_pkg::BIT_PEND;
  localparam logic [5:0]  POL = 6'h04;
  localparam logic [5:0]  EN  = 6'h07;
  logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, err, irq, wake;
  logic        vfa = 0, brk = 0, bce = 0;
  logic [5:0]  keys, pu, pd, fi, drv_en = '0, drv_val = '0;
  int          miscompares = 0, n_checks = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  kpi_keypad_irq #(.N(6)) kpi_keypad_irq_inst (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .keypad_inputs(keys), .vector_fetch_ack(vfa), .break_state(brk),
    .break_clear_enable(bce), .irq_req(irq), .wake_req(wake), .pull_up_en(pu),
    .pull_down_en(pd), .pin_force_input(fi));
  kpi_key_model #(.N(6)) kpi_key_model_inst (.pclk(pclk), .drv_en(drv_en),
    .drv_val(drv_val), .pu_en(pu), .pd_en(pd), .keys(keys));
  //=====
  task test_done;
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      miscompares++;
    end
  endtask
  // one idle edge first so a strobe is never dropped and raised in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
      $display("[FAIL] pready exp 1 got %b", pready);
      miscompares++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  // synchroniser plus latch stage, with margin
  task settle;
    repeat (8) @(posedge pclk);
  endtask
  task press(input int i);
    drv_en[i] <= 1'b1;
    drv_val[i] <= POL[i];
  endtask
  task rel(input int i);
    drv_en[i] <= 1'b0;
  endtask
  //=====
  task t_reset;
    rdc("status", kpi_pkg::OFF_STATUS, 32'h0000_0000);
    rdc("enable", kpi_pkg::OFF_ENABLE, 32'h0000_0000);
    rdc("polarity", kpi_pkg::OFF_POLARITY, 32'h0000_0000);
    rdc("unmapped", 12'h00C, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, err});
  endtask
  task t_init;
    wr(kpi_pkg::OFF_STATUS, MK);
    wr(kpi_pkg::OFF_POLARITY, {26'h0, POL});
    wr(kpi_pkg::OFF_ENABLE, {26'h0, EN});
    rdc("enable", kpi_pkg::OFF_ENABLE, {26'h0, EN});
    settle;
    wr(kpi_pkg::OFF_STATUS, MK | AK);
    rdc("status", kpi_pkg::OFF_STATUS, MK);
    wr(kpi_pkg::OFF_STATUS, 32'h0000_0000);
    chk("pullup", {26'h0, EN & ~POL}, {26'h0, pu});
    chk("pulldown", {26'h0, EN & POL}, {26'h0, pd});
    chk("force_in", {26'h0, EN}, {26'h0, fi});
  endtask
  task t_edge;
    press(0);
    settle;
    chk("irq", 32'h1, {31'h0, irq});
    rdc("status", kpi_pkg::OFF_STATUS, PN);
    wr(kpi_pkg::OFF_STATUS, MK);
    rdc("status", kpi_pkg::OFF_STATUS, MK | PN);
    chk("irq", 32'h0, {31'h0, irq});
    chk("wake", 32'h0, {31'h0, wake});
    wr(kpi_pkg::OFF_STATUS, MK | AK);
    rdc("status", kpi_pkg::OFF_STATUS, MK);
    press(2);
    settle;
    rdc("status", kpi_pkg::OFF_STATUS, MK);
    rel(0);
    rel(2);
    settle;
    press(1);
    settle;
    rdc("status", kpi_pkg::OFF_STATUS, MK | PN);
    vfa <= 1'b1;
    @(posedge pclk);
    vfa <= 1'b0;
    settle;
    rdc("status", kpi_pkg::OFF_STATUS, MK);
    rel(1);
    settle;
  endtask
  task t_level;
    wr(kpi_pkg::OFF_STATUS, MD);
    press(0);
    settle;
    wr(kpi_pkg::OFF_STATUS, MD | AK);
    settle;
    rdc("status", kpi_pkg::OFF_STATUS, MD | PN);
    chk("wake", 32'h1, {31'h0, wake});
    rel(0);
    settle;
    rdc("status", kpi_pkg::OFF_STATUS, MD);
    press(2);
    settle;
    rel(2);
    settle;
    rdc("status", kpi_pkg::OFF_STATUS, MD | PN);
    wr(kpi_pkg::OFF_STATUS, MD | AK);
    rdc("status", kpi_pkg::OFF_STATUS, MD);
  endtask
  task t_freeze;
    clk_en <= 1'b0;
    press(1);
    settle;
    chk("irq_frozen", 32'h0, {31'h0, irq});
    clk_en <= 1'b1;
    settle;
    chk("irq", 32'h1, {31'h0, irq});
    rel(1);
    settle;
    wr(kpi_pkg::OFF_STATUS, MD | AK);
    rdc("status", kpi_pkg::OFF_STATUS, MD);
  endtask
  task t_break;
    wr(kpi_pkg::OFF_STATUS, 32'h0000_0000);
    press(1);
    settle;
    brk <= 1'b1;
    wr(kpi_pkg::OFF_STATUS, AK);
    rdc("status", kpi_pkg::OFF_STATUS, PN);
    bce <= 1'b1;
    wr(kpi_pkg::OFF_STATUS, AK);
    brk <= 1'b0;
    bce <= 1'b0;
    rdc("status", kpi_pkg::OFF_STATUS, 32'h0000_0000);
    rel(1);
    settle;
  endtask
  task t_rst_mid;
    wr(kpi_pkg::OFF_STATUS, MD);
    press(0);
    settle;
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    chk("irq", 32'h0, {31'h0, irq});
    rdc("status", kpi_pkg::OFF_STATUS, 32'h0000_0000);
    rel(0);
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_init;
    t_edge;
    t_level;
    t_freeze;
    t_break;
    t_rst_mid;
    test_done;
  end
endmodule // test_keypad_pin_interrupt
